// [shared/tncd_pkg.sv]
// Purpose: Shared constants and types for the token network command decoder
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Register offsets are byte addresses
package tncd_pkg;
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_CONFIG = 8'h0C;
	localparam logic [7:0] CMD_CLR_TX_INT = 8'h00;
	localparam logic [7:0] CMD_DIS_TX = 8'h01;
	localparam logic [7:0] CMD_DIS_RX = 8'h02;
	localparam logic [7:0] CMD_CLR_RX_INT = 8'h08;
	localparam logic [7:0] MSK_RX_EN = 8'h47;
	localparam logic [7:0] PAT_RX_EN = 8'h04;
	localparam logic [7:0] MSK_TX_EN = 8'hC7;
	localparam logic [7:0] PAT_TX_EN = 8'h03;
	localparam logic [7:0] MSK_DEFCFG = 8'hF7;
	localparam logic [7:0] PAT_DEFCFG = 8'h05;
	localparam logic [7:0] MSK_CLRFLG = 8'hE7;
	localparam logic [7:0] PAT_CLRFLG = 8'h06;
	localparam int BIT_BCAST = 7;
	localparam int BIT_RECONFIG = 4;
	localparam int BIT_FINE = 5;
	localparam int BIT_POR = 3;
	localparam int BIT_LONG = 3;
	localparam int PAGE_LSB = 3;
	localparam logic [10:0] PAGE_BYTES = 11'h200;
	localparam logic [10:0] FINE_OFFSET = 11'h100;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Status bit positions
	localparam int ST_TXFREE = 0;
	localparam int ST_TXACK = 1;
	localparam int ST_RXIDLE = 7;
	localparam int ST_POR = 4;
	localparam int ST_RECONFIG = 2;
	localparam int ST_REFUSALS = 3;

	typedef struct packed {
		logic transmitterFree;
		logic transmitAcked;
		logic receiverIdleFlag;
		logic porFlag;
		logic reconfigFlag;
		logic excessRefusalsFlag;
	} tncd_flags_s;

	typedef struct packed {
		logic armed;
		logic [10:0] startAddr;
		logic bcast;
	} tncd_arm_s;
endpackage

// [rtl/tncd_top.sv]
// Purpose: Command register decoder with AXI4-Lite slave and status flags
// Assumes: Network engine supplies token and transfer events on core_clk
// Notes: Event inputs are same-domain one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1 - Recognise the two clear-interrupt codes
// R2 - Disable transmitter cancels queued unstarted transmit
// R3 - Transmitter free sets at next token
// R4 - Disable receiver cancels arm; idle at token
// R5 - Ongoing reception finishes despite disable
// R6 - Receive arm selects page, clears idle
// R7 - Fine bit adds 256 bytes receive
// R8 - Broadcast bit accepts identifier zero packets
// R9 - Successful reception sets receiver idle
// R10 - Transmit arm starts at next token
// R11 - Fine bit adds 256 bytes transmit
// R12 - Transmit arm clears free and acked
// R13 - Transmit completion sets transmitter free
// R14 - Acked set by completion when acknowledged
// R15 - Acknowledge returned by hardware on reception
// R16 - Length mode selects long or short
// R17 - Clear flags p clears power-up, refusals
// R18 - Clear flags r clears reconfiguration
// R19 - Free flag with mask raises interrupt
// R20 - Undefined codes change nothing
module tncd_top import tncd_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tokenSeen,
	input wire logic txDone,
	input wire logic ackSeen,
	input wire logic rxStart,
	input wire logic rxGood,
	input wire logic rxEnd,
	input wire logic porEvent,
	input wire logic reconfigEvent,
	input wire logic refusalsEvent,
	output logic txStart,
	output logic [10:0] txStartAddr,
	output logic rxArmed,
	output logic [10:0] rxStartAddr,
	output logic rxBroadcast,
	output logic rxAckSend,
	output logic longPackets,
	output logic chainTxIntClr,
	output logic chainRxIntClr,
	output logic txFreeIrq
);
	function automatic logic [10:0] pageAddr(input logic [7:0] code);
		pageAddr = 11'(code[PAGE_LSB+1:PAGE_LSB]) * PAGE_BYTES
			+ (code[BIT_FINE] ? FINE_OFFSET : 11'h000);
	endfunction

	function automatic logic hit(input logic [7:0] code, input logic [7:0] msk,
		input logic [7:0] pat);
		hit = (code & msk) == pat;
	endfunction

	// Bus state
	logic awHeld_ff, nxt_awHeld;
	logic wHeld_ff, nxt_wHeld;
	logic [7:0] awAddr_ff, nxt_awAddr;
	logic [31:0] wData_ff, nxt_wData;
	logic [3:0] wStrb_ff, nxt_wStrb;
	logic bValid_ff, nxt_bValid;
	logic [1:0] bResp_ff, nxt_bResp;
	logic rValid_ff, nxt_rValid;
	logic [31:0] rData_ff, nxt_rData;
	logic [1:0] rResp_ff, nxt_rResp;
	// Block state
	tncd_flags_s flags_ff, nxt_flags;
	tncd_arm_s txArm_ff, nxt_txArm;
	tncd_arm_s rxArm_ff, nxt_rxArm;
	logic txPendFree_ff, nxt_txPendFree;
	logic rxPendIdle_ff, nxt_rxPendIdle;
	logic rxBusy_ff, nxt_rxBusy;
	logic txBusy_ff, nxt_txBusy;
	logic longMode_ff, nxt_longMode;
	logic [7:0] mask_ff, nxt_mask;
	logic txStart_ff, nxt_txStart;
	logic ack_ff, nxt_ack;
	logic chainTx_ff, nxt_chainTx;
	logic chainRx_ff, nxt_chainRx;

	logic doWrite;
	logic cmdWrite;
	logic [7:0] cmd;
	logic [7:0] statusByte;

	always_comb begin
		statusByte = 8'h00;
		statusByte[ST_TXFREE] = flags_ff.transmitterFree;
		statusByte[ST_TXACK] = flags_ff.transmitAcked;
		statusByte[ST_RXIDLE] = flags_ff.receiverIdleFlag;
		statusByte[ST_POR] = flags_ff.porFlag;
		statusByte[ST_RECONFIG] = flags_ff.reconfigFlag;
		statusByte[ST_REFUSALS] = flags_ff.excessRefusalsFlag;
	end

	assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
	assign cmdWrite = doWrite && awAddr_ff == OFF_CMD && wStrb_ff[0];
	assign cmd = wData_ff[7:0];

	// AXI4-Lite slave: address and data taken in either order
	always_comb begin
		nxt_awHeld = awHeld_ff;
		nxt_wHeld = wHeld_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wData = wData_ff;
		nxt_wStrb = wStrb_ff;
		nxt_bValid = bValid_ff;
		nxt_bResp = bResp_ff;
		nxt_rValid = rValid_ff;
		nxt_rData = rData_ff;
		nxt_rResp = rResp_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_wHeld = 1'b1;
			nxt_wData = s_axi_wdata;
			nxt_wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
			nxt_bValid = 1'b1;
			nxt_bResp = (awAddr_ff == OFF_CMD || awAddr_ff == OFF_MASK
				|| awAddr_ff == OFF_CONFIG || awAddr_ff == OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bValid_ff && s_axi_bready) begin
			nxt_bValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rValid = 1'b1;
			nxt_rResp = RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				OFF_CMD: nxt_rData = 32'h0000_0000;
				OFF_STATUS: nxt_rData = {24'h000000, statusByte};
				OFF_MASK: nxt_rData = {24'h000000, mask_ff};
				OFF_CONFIG: nxt_rData = {31'h00000000, longMode_ff};
				default: begin
					nxt_rData = 32'h0000_0000;
					nxt_rResp = RESP_SLVERR;
				end
			endcase
		end
		if (rValid_ff && s_axi_rready) begin
			nxt_rValid = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
			bValid_ff <= 1'b0;
			bResp_ff <= RESP_OKAY;
			rValid_ff <= 1'b0;
			rData_ff <= 32'h0000_0000;
			rResp_ff <= RESP_OKAY;
		end else begin
			awHeld_ff <= nxt_awHeld;
			wHeld_ff <= nxt_wHeld;
			awAddr_ff <= nxt_awAddr;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			bValid_ff <= nxt_bValid;
			bResp_ff <= nxt_bResp;
			rValid_ff <= nxt_rValid;
			rData_ff <= nxt_rData;
			rResp_ff <= nxt_rResp;
		end
	end

	// Command decode and status flags; hardware events applied after commands so sets win
	always_comb begin
		nxt_flags = flags_ff;
		nxt_txArm = txArm_ff;
		nxt_rxArm = rxArm_ff;
		nxt_txPendFree = txPendFree_ff;
		nxt_rxPendIdle = rxPendIdle_ff;
		nxt_rxBusy = rxBusy_ff;
		nxt_txBusy = txBusy_ff;
		nxt_longMode = longMode_ff;
		nxt_mask = mask_ff;
		nxt_txStart = 1'b0;
		nxt_ack = 1'b0;
		nxt_chainTx = 1'b0;
		nxt_chainRx = 1'b0;
		if (doWrite && awAddr_ff == OFF_MASK && wStrb_ff[0]) begin
			nxt_mask = wData_ff[7:0];
		end
		if (doWrite && awAddr_ff == OFF_CONFIG && wStrb_ff[0]) begin
			nxt_longMode = wData_ff[0];
		end
		if (cmdWrite) begin
			if (cmd == CMD_CLR_TX_INT) begin
				nxt_chainTx = 1'b1; // [R1]
			end else if (cmd == CMD_CLR_RX_INT) begin
				nxt_chainRx = 1'b1; // [R1]
			end else if (cmd == CMD_DIS_TX) begin
				nxt_txArm.armed = 1'b0; // [R2]
				nxt_txPendFree = 1'b1; // [R3]
			end else if (cmd == CMD_DIS_RX) begin
				nxt_rxArm.armed = 1'b0; // [R4]
				nxt_rxPendIdle = !rxBusy_ff; // [R4] [R5]
			end else if (hit(cmd, MSK_RX_EN, PAT_RX_EN)) begin
				nxt_rxArm.armed = 1'b1; // [R6]
				nxt_rxArm.startAddr = pageAddr(cmd); // [R6] [R7]
				nxt_rxArm.bcast = cmd[BIT_BCAST]; // [R8]
				nxt_rxPendIdle = 1'b0;
				nxt_flags.receiverIdleFlag = 1'b0; // [R6]
			end else if (hit(cmd, MSK_TX_EN, PAT_TX_EN)) begin
				nxt_txArm.armed = 1'b1; // [R10]
				nxt_txArm.startAddr = pageAddr(cmd); // [R11]
				nxt_txArm.bcast = 1'b0;
				nxt_txPendFree = 1'b0;
				nxt_flags.transmitterFree = 1'b0; // [R12]
				nxt_flags.transmitAcked = 1'b0; // [R12]
			end else if (hit(cmd, MSK_DEFCFG, PAT_DEFCFG)) begin
				nxt_longMode = cmd[BIT_LONG]; // [R16]
			end else if (hit(cmd, MSK_CLRFLG, PAT_CLRFLG)) begin
				if (cmd[BIT_POR]) begin
					nxt_flags.porFlag = 1'b0; // [R17]
					nxt_flags.excessRefusalsFlag = 1'b0; // [R17]
				end
				if (cmd[BIT_RECONFIG]) begin
					nxt_flags.reconfigFlag = 1'b0; // [R18]
				end
			end
			// Other codes fall through untouched [R20]
		end
		if (tokenSeen) begin
			if (txArm_ff.armed && !txBusy_ff) begin
				nxt_txStart = 1'b1; // [R10]
				nxt_txBusy = 1'b1;
				nxt_txArm.armed = 1'b0;
			end
			if (txPendFree_ff) begin
				nxt_flags.transmitterFree = 1'b1; // [R3]
				nxt_txPendFree = 1'b0;
			end
			if (rxPendIdle_ff) begin
				nxt_flags.receiverIdleFlag = 1'b1; // [R4]
				nxt_rxPendIdle = 1'b0;
			end
		end
		if (txBusy_ff && ackSeen) begin
			nxt_flags.transmitAcked = 1'b1; // [R14]
		end
		if (txBusy_ff && txDone) begin
			nxt_txBusy = 1'b0;
			nxt_flags.transmitterFree = 1'b1; // [R13]
			nxt_flags.transmitAcked = flags_ff.transmitAcked | ackSeen; // [R14]
		end
		// An armed reception keeps running even if disabled midway
		if (rxStart && rxArm_ff.armed) begin
			nxt_rxBusy = 1'b1; // [R5]
		end
		if (rxBusy_ff && rxEnd) begin
			nxt_rxBusy = 1'b0;
			nxt_rxArm.armed = 1'b0;
			if (rxGood) begin
				nxt_ack = 1'b1; // [R15]
				nxt_flags.receiverIdleFlag = 1'b1; // [R9]
			end
		end
		if (porEvent) begin
			nxt_flags.porFlag = 1'b1;
		end
		if (reconfigEvent) begin
			nxt_flags.reconfigFlag = 1'b1;
		end
		if (refusalsEvent) begin
			nxt_flags.excessRefusalsFlag = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			flags_ff <= '{transmitterFree: 1'b1, transmitAcked: 1'b0, receiverIdleFlag: 1'b1,
				porFlag: 1'b1, reconfigFlag: 1'b0, excessRefusalsFlag: 1'b0};
			txArm_ff <= '0;
			rxArm_ff <= '0;
			txPendFree_ff <= 1'b0;
			rxPendIdle_ff <= 1'b0;
			rxBusy_ff <= 1'b0;
			txBusy_ff <= 1'b0;
			longMode_ff <= 1'b0;
			mask_ff <= MASK_RESET;
			txStart_ff <= 1'b0;
			ack_ff <= 1'b0;
			chainTx_ff <= 1'b0;
			chainRx_ff <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			txArm_ff <= nxt_txArm;
			rxArm_ff <= nxt_rxArm;
			txPendFree_ff <= nxt_txPendFree;
			rxPendIdle_ff <= nxt_rxPendIdle;
			rxBusy_ff <= nxt_rxBusy;
			txBusy_ff <= nxt_txBusy;
			longMode_ff <= nxt_longMode;
			mask_ff <= nxt_mask;
			txStart_ff <= nxt_txStart;
			ack_ff <= nxt_ack;
			chainTx_ff <= nxt_chainTx;
			chainRx_ff <= nxt_chainRx;
		end
	end

	// Bus ready: one write and one read in flight at most
	assign s_axi_awready = !awHeld_ff && !bValid_ff;
	assign s_axi_wready = !wHeld_ff && !bValid_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_bresp = bResp_ff;
	assign s_axi_arready = !rValid_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_rresp = rResp_ff;

	assign txStart = txStart_ff;
	assign txStartAddr = txArm_ff.startAddr;
	assign rxArmed = rxArm_ff.armed;
	assign rxStartAddr = rxArm_ff.startAddr;
	assign rxBroadcast = rxArm_ff.bcast;
	assign rxAckSend = ack_ff;
	assign longPackets = longMode_ff;
	assign chainTxIntClr = chainTx_ff;
	assign chainRxIntClr = chainRx_ff;
	assign txFreeIrq = flags_ff.transmitterFree & mask_ff[ST_TXFREE]; // [R19]
endmodule // tncd_top
`default_nettype wire

// [tb/tncd_net_model.sv]
// Purpose: Network engine stand-in for the command decoder
// Assumes: Bench requests token and receive traffic
// Notes: DLY sets how slowly transfers finish
`timescale 1ns/100ps
`default_nettype none
module tncd_net_model #(
	parameter int DLY = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic tokReq,
	input wire logic rxReq,
	input wire logic good,
	input wire logic txStart,
	output logic tokenSeen,
	output logic txDone,
	output logic ackSeen,
	output logic rxStart,
	output logic rxEnd,
	output logic rxGood
);
	logic [4:0] txCnt;
	logic [4:0] rxCnt;
	always_ff @(posedge core_clk) begin
		tokenSeen <= tokReq && !rst;
		txDone <= 1'h0;
		ackSeen <= 1'h0;
		rxStart <= 1'h0;
		rxEnd <= 1'h0;
		// Outside the end pulse the quality line carries junk
		rxGood <= !good;
		if (rst) begin
			txCnt <= 5'h0;
			rxCnt <= 5'h0;
		end else begin
			if (txStart) begin
				txCnt <= 5'(DLY);
			end else if (txCnt != 5'h0) begin
				txCnt <= txCnt - 5'h1;
				ackSeen <= txCnt == 5'h2 && good;
				txDone <= txCnt == 5'h1;
			end
			if (rxReq) begin
				rxStart <= 1'h1;
				rxCnt <= 5'(DLY);
			end else if (rxCnt != 5'h0) begin
				rxCnt <= rxCnt - 5'h1;
				rxEnd <= rxCnt == 5'h1;
				if (rxCnt == 5'h1) begin
					rxGood <= good;
				end
			end
		end
	end
endmodule // tncd_net_model
`default_nettype wire

// [tb/tncd_asserts.sv]
// Purpose: Port checks for the command decoder
// Assumes: One clock, sync reset
// Notes: Command effects land with the write response
`timescale 1ns/100ps
`default_nettype none
module tncd_asserts (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic tokenSeen,
	input wire logic rxEnd,
	input wire logic rxGood,
	input wire logic txStart,
	input wire logic [10:0] txStartAddr,
	input wire logic rxArmed,
	input wire logic [10:0] rxStartAddr,
	input wire logic rxAckSend,
	input wire logic longPackets,
	input wire logic chainTxIntClr,
	input wire logic chainRxIntClr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence sWrDone;
		$rose(s_axi_bvalid);
	endsequence
	AST_TX_TOKEN: assert property (txStart |-> $past(tokenSeen))
		else $error("tx start without token");
	AST_TX_ONCE: assert property (txStart |=> !txStart)
		else $error("tx start repeated");
	AST_TX_ADDR: assert property (txStart |-> txStartAddr[7:0] == 8'h00)
		else $error("tx address off page");
	AST_RX_ADDR: assert property (rxArmed |-> rxStartAddr[7:0] == 8'h00)
		else $error("rx address off page");
	AST_RX_ARM: assert property ($rose(rxArmed) |-> sWrDone)
		else $error("rx armed without command");
	AST_RX_DROP: assert property ($fell(rxArmed) |-> sWrDone or $past(rxEnd))
		else $error("rx arm lost");
	AST_ACK_HW: assert property (rxAckSend |-> $past(rxEnd) && $past(rxGood))
		else $error("ack without good end");
	AST_LEN_MODE: assert property ($changed(longPackets) |-> sWrDone)
		else $error("length mode changed alone");
	AST_CHAIN: assert property (chainTxIntClr || chainRxIntClr |-> sWrDone)
		else $error("chain clear without command");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule // tncd_asserts
bind tncd_top tncd_asserts chk_i (.*);
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Command and flag tests over the register bus
// Assumes: Net model paces token and receive traffic
// Notes: Status bits 0 free, 1 acked, 2 reconfig, 3 refusals, 4 power-up, 7 idle
`timescale 1ns/100ps
`default_nettype none
module testbench import tncd_pkg::*;;
	localparam int DLY = 8;
	logic core_clk = 1'h0, rst = 1'h1;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic tokReq = 1'h0, rxReq = 1'h0, good = 1'h1;
	logic porEvent = 1'h0, reconfigEvent = 1'h0, refusalsEvent = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic tokenSeen, txDone, ackSeen, rxStart, rxGood, rxEnd, txStart, rxArmed;
	logic rxBroadcast, rxAckSend, longPackets, chainTxIntClr, chainRxIntClr, txFreeIrq;
	logic [10:0] txStartAddr, rxStartAddr, txA = 11'h0;
	logic [7:0] nTx = 8'h0, nAck = 8'h0, nCt = 8'h0, nCr = 8'h0;
	int errTotal = 0, checks = 0;
	always #2.5 core_clk = ~core_clk;
	tncd_top dut (.*);
	tncd_net_model #(.DLY(DLY)) net (.*);
	// Pulses are counted so that no check has to hit their one cycle
	always @(posedge core_clk) begin
		if (txStart) begin
			nTx <= nTx + 8'h1;
			txA <= txStartAddr;
		end
		if (rxAckSend) nAck <= nAck + 8'h1;
		if (chainTxIntClr) nCt <= nCt + 8'h1;
		if (chainRxIntClr) nCr <= nCr + 8'h1;
	end
	task automatic results;
		if (errTotal == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Handshakes are judged at the falling edge so no update race can mislead them
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		logic aw, w, b;
		logic [1:0] rsp;
		@(posedge core_clk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge core_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			rsp = s_axi_bresp;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
			if (b) s_axi_bready <= 1'h0;
		end while (!b);
		chk(rsp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		logic ar, r;
		logic [31:0] dat;
		logic [1:0] rsp;
		@(posedge core_clk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(negedge core_clk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid && s_axi_rready;
			dat = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'h0;
			if (r) s_axi_rready <= 1'h0;
		end while (!r);
		chk(dat, exp);
		chk(rsp, er);
	endtask
	// Bits: token, receive, reconfig plus refusal flags
	task automatic go(input logic [2:0] e);
		@(posedge core_clk);
		{tokReq, rxReq, reconfigEvent, refusalsEvent} <= {e, e[0]};
		@(posedge core_clk);
		{tokReq, rxReq, reconfigEvent, refusalsEvent} <= 4'h0;
	endtask
	task automatic idle;
		repeat (DLY + 4) @(posedge core_clk);
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'h0;
		rd(OFF_STATUS, 32'h91);
		rd(OFF_MASK, 32'h0);
		rd(OFF_CMD, 32'h0);
		wr(8'h10, 8'h01, RESP_SLVERR);
		rd(8'h10, 32'h0, RESP_SLVERR);
		wr(OFF_MASK, 8'h01);
		chk(txFreeIrq, 1'h1);
		wr(OFF_CMD, 8'h3B);
		rd(OFF_STATUS, 32'h90);
		chk(txFreeIrq, 1'h0);
		go(3'h4);
		idle;
		chk({nTx, txA}, {8'h1, 11'h700});
		rd(OFF_STATUS, 32'h93);
		wr(OFF_CMD, 8'h03);
		wr(OFF_CMD, CMD_DIS_TX);
		rd(OFF_STATUS, 32'h90);
		go(3'h4);
		idle;
		chk(nTx, 8'h1);
		rd(OFF_STATUS, 32'h91);
		wr(OFF_CMD, 8'hAC);
		chk({rxArmed, rxBroadcast, rxStartAddr}, {2'h3, 11'h300});
		rd(OFF_STATUS, 32'h11);
		go(3'h2);
		idle;
		chk({nAck, rxArmed}, {8'h1, 1'h0});
		rd(OFF_STATUS, 32'h91);
		wr(OFF_CMD, 8'h04);
		go(3'h2);
		wr(OFF_CMD, CMD_DIS_RX);
		idle;
		chk(nAck, 8'h2);
		good <= 1'h0;
		wr(OFF_CMD, 8'h0B);
		wr(OFF_CMD, 8'h04);
		go(3'h6);
		idle;
		chk({nTx, txA, nAck}, {8'h2, 11'h200, 8'h2});
		rd(OFF_STATUS, 32'h11);
		good <= 1'h1;
		wr(OFF_CMD, 8'h04);
		wr(OFF_CMD, CMD_DIS_RX);
		chk(rxArmed, 1'h0);
		rd(OFF_STATUS, 32'h11);
		go(3'h4);
		idle;
		rd(OFF_STATUS, 32'h91);
		wr(OFF_CMD, 8'h0D);
		chk(longPackets, 1'h1);
		rd(OFF_CONFIG, 32'h1);
		wr(OFF_CMD, 8'h05);
		chk(longPackets, 1'h0);
		go(3'h1);
		rd(OFF_STATUS, 32'h9D);
		wr(OFF_CMD, 8'h0E);
		rd(OFF_STATUS, 32'h85);
		wr(OFF_CMD, 8'h16);
		rd(OFF_STATUS, 32'h81);
		wr(OFF_CMD, 8'hFF);
		rd(OFF_STATUS, 32'h81);
		chk({longPackets, rxArmed, nTx}, {2'h0, 8'h2});
		wr(OFF_CMD, CMD_CLR_TX_INT);
		wr(OFF_CMD, CMD_CLR_RX_INT);
		idle;
		chk({nCt, nCr}, 16'h0101);
		results();
	end
	initial begin
		repeat (3000) @(posedge core_clk);
		errTotal++;
		results();
	end
endmodule // testbench
`default_nettype wire
